// ===== rtl/icc_regs.vh
// Register map and timing constants of the configuration checksum checker
`ifndef ICC_REGS_VH
`define ICC_REGS_VH

// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define ICC_ADDR_CTRL 8'h00
`define ICC_ADDR_STAT 8'h04

// ==========================================================================
// Control register fields
`define ICC_REF_LSB 0
`define ICC_REF_MSB 7
`define ICC_ACTION_BIT 9
`define ICC_FLAG_BIT 12
`define ICC_MASK_BIT 13
`define ICC_CTRL_RESET 16'h0000

// ==========================================================================
// Status register fields
`define ICC_STAT_CRC_LSB 0
`define ICC_STAT_CRC_MSB 7
`define ICC_STAT_LAST_BAD 8
`define ICC_STAT_LIMP 9
`define ICC_STAT_CHECKS_LSB 16
`define ICC_STAT_CHECKS_MSB 23

// ==========================================================================
// Timing
`define ICC_CLK_MHZ 200
`define ICC_CHECK_PERIOD_US 5000
`define ICC_CHECK_CYCLES (`ICC_CHECK_PERIOD_US * `ICC_CLK_MHZ)

// ==========================================================================
// Checksum defaults
`define ICC_CRC_POLY 8'h07
`define ICC_CRC_INIT 8'h00

`endif

// ===== rtl/icc_crc8.v
// Combinational 8-bit CRC over the configuration image
`timescale 1ns/1ps
module icc_crc8
#(
    parameter CFG_W = 64,
    parameter [7:0] POLY = 8'h07,
    parameter [7:0] INIT = 8'h00
)
(
    input wire [CFG_W-1:0] data,
    output reg [7:0] crc
);

integer i;
reg fb;

// MSB of the image is shifted in first
always @*
begin
    crc = INIT;
    fb = 1'b0;
    for (i = CFG_W - 1; i >= 0; i = i - 1)
    begin
        fb = crc[7] ^ data[i];
        crc = {crc[6:0], 1'b0};
        if (fb)
        begin
            crc = crc ^ POLY;
        end
    end
end

endmodule // icc_crc8

// ===== rtl/icc_checker.v
// Periodic configuration checksum checker with Wishbone register access
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "icc_regs.vh"
module icc_checker
#(
    parameter CFG_W = 64,
    parameter CNT_W = 20,
    parameter [CNT_W-1:0] CHECK_CYCLES = `ICC_CHECK_CYCLES,
    parameter [7:0] CRC_POLY = `ICC_CRC_POLY,
    parameter [7:0] CRC_INIT = `ICC_CRC_INIT
)
(
    input wire REF_CLK,
    input wire RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire NORMAL_MODE,
    input wire [CFG_W-1:0] CFG_DATA,
    output reg IRQ,
    output reg LIMP_HOME
);

// ==========================================================================
// Reset release
reg rst_meta_n;
reg rst_n;

always @(posedge REF_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        rst_meta_n <= 1'b0;
        rst_n <= 1'b0;
    end
    else
    begin
        rst_meta_n <= 1'b1;
        rst_n <= rst_meta_n;
    end
end

// ==========================================================================
// Checksum of the live configuration image
wire [7:0] crc_now;

icc_crc8
#(
    .CFG_W(CFG_W),
    .POLY(CRC_POLY),
    .INIT(CRC_INIT)
)
u_crc
(
    .data(CFG_DATA),
    .crc(crc_now)
);

// ==========================================================================
// Bus decode
wire bus_req;
wire wr_ctrl;
wire sel_ctrl;
wire sel_stat;

assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
assign sel_ctrl = (WB_ADR_I == `ICC_ADDR_CTRL);
assign sel_stat = (WB_ADR_I == `ICC_ADDR_STAT);
assign wr_ctrl = bus_req & WB_WE_I & sel_ctrl;

// ==========================================================================
// Check interval timer
reg [CNT_W-1:0] tick_cnt;
reg check_now;

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        tick_cnt <= {CNT_W{1'b0}};
        check_now <= 1'b0;
    end
    else if (!NORMAL_MODE)
    begin
        // Restart the interval so a full period follows mode entry
        tick_cnt <= {CNT_W{1'b0}};
        check_now <= 1'b0;
    end
    else if (tick_cnt == CHECK_CYCLES - 1'b1)
    begin
        tick_cnt <= {CNT_W{1'b0}};
        check_now <= 1'b1;
    end
    else
    begin
        tick_cnt <= tick_cnt + 1'b1;
        check_now <= 1'b0;
    end
end

// ==========================================================================
// Control and status register fields
reg [7:0] ref_crc;
reg fail_action;
reg err_flag;
reg irq_mask;
reg last_bad;
reg [7:0] last_crc;
reg [7:0] check_count;
wire mismatch;
reg next_err_flag;

// Mode may drop in the pulse cycle; gate again so no check runs outside
assign mismatch = check_now & NORMAL_MODE & (crc_now != ref_crc);

always @*
begin
    next_err_flag = err_flag;
    if (wr_ctrl && WB_SEL_I[1] && WB_DAT_I[`ICC_FLAG_BIT])
    begin
        next_err_flag = 1'b0;
    end
    // A detection in the clear cycle still sticks
    if (mismatch)
    begin
        next_err_flag = 1'b1;
    end
end

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        ref_crc <= 8'h00;
        fail_action <= 1'b0;
        err_flag <= 1'b0;
        irq_mask <= 1'b0;
        last_bad <= 1'b0;
        last_crc <= 8'h00;
        check_count <= 8'h00;
    end
    else
    begin
        err_flag <= next_err_flag;
        if (wr_ctrl && WB_SEL_I[0])
        begin
            ref_crc <= WB_DAT_I[`ICC_REF_MSB:`ICC_REF_LSB];
        end
        if (wr_ctrl && WB_SEL_I[1])
        begin
            fail_action <= WB_DAT_I[`ICC_ACTION_BIT];
            irq_mask <= WB_DAT_I[`ICC_MASK_BIT];
        end
        if (check_now && NORMAL_MODE)
        begin
            last_bad <= (crc_now != ref_crc);
            last_crc <= crc_now;
            check_count <= check_count + 8'h01;
        end
    end
end

// ==========================================================================
// Outputs
always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        IRQ <= 1'b0;
        LIMP_HOME <= 1'b0;
    end
    else
    begin
        IRQ <= next_err_flag & ~irq_mask;
        // Held while the flag and the action bit stand; software releases it by clearing either
        LIMP_HOME <= next_err_flag & fail_action;
    end
end

// ==========================================================================
// Wishbone answer: ack one cycle after the request, unmapped reads zero
reg [31:0] rd_word;

always @*
begin
    rd_word = 32'h0000_0000;
    if (sel_ctrl)
    begin
        rd_word[`ICC_REF_MSB:`ICC_REF_LSB] = ref_crc;
        rd_word[`ICC_ACTION_BIT] = fail_action;
        rd_word[`ICC_FLAG_BIT] = err_flag;
        rd_word[`ICC_MASK_BIT] = irq_mask;
    end
    else if (sel_stat)
    begin
        rd_word[`ICC_STAT_CRC_MSB:`ICC_STAT_CRC_LSB] = last_crc;
        rd_word[`ICC_STAT_LAST_BAD] = last_bad;
        rd_word[`ICC_STAT_LIMP] = LIMP_HOME;
        rd_word[`ICC_STAT_CHECKS_MSB:`ICC_STAT_CHECKS_LSB] = check_count;
    end
end

always @(posedge REF_CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        WB_ACK_O <= 1'b0;
        WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
        WB_ACK_O <= bus_req;
        if (bus_req && !WB_WE_I)
        begin
            WB_DAT_O <= rd_word;
        end
        else
        begin
            WB_DAT_O <= 32'h0000_0000;
        end
    end
end

endmodule // icc_checker

// ===== tb/icc_checker_sva.sv
// Port assertions for the checksum checker
`timescale 1ns/1ps
module icc_checker_sva (
    input wire REF_CLK,
    input wire RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire NORMAL_MODE,
    input wire IRQ,
    input wire LIMP_HOME
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    wire wr1 = WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00 && WB_SEL_I[1];
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    AST_ACK_TIMELY: assert property
        (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
    AST_RESET_QUIET: assert property
        ($rose(RST_N) |-> !IRQ && !LIMP_HOME) else $error("out after reset");
    // Check pulse is a few cycles behind the mode input
    AST_SET_IN_NORMAL: assert property
        ($rose(IRQ || LIMP_HOME) && !$past(WB_ACK_O) |-> $past(NORMAL_MODE, 2)
        || $past(NORMAL_MODE, 3) || $past(NORMAL_MODE, 4)) else $error("mode");
    AST_CTRL_ZEROS: assert property
        (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h00
        |-> (WB_DAT_O & 32'hFFFF_CD00) == 32'h0) else $error("ctrl bits");
    AST_FLAG_CLEARS: assert property
        (wr1 && WB_DAT_I[12] && !(NORMAL_MODE || $past(NORMAL_MODE)
        || $past(NORMAL_MODE, 2)) |=> !IRQ && !LIMP_HOME)
        else $error("flag kept");
    AST_MASK_HIDES: assert property (wr1 && WB_DAT_I[13] |=> !IRQ)
        else $error("irq masked");
    AST_ACTION_OFF: assert property
        (wr1 && !WB_DAT_I[9] |=> !LIMP_HOME)
        else $error("limp off");
endmodule // icc_checker_sva
bind icc_checker icc_checker_sva icc_checker_sva_i (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O),
    .NORMAL_MODE(NORMAL_MODE),
    .IRQ(IRQ),
    .LIMP_HOME(LIMP_HOME)
);

// ===== tb/icc_host.sv
// Host checksum model: MSB-first CRC-8 over the image
`timescale 1ns/1ps
module icc_host (
    input wire [63:0] cfg,
    output logic [7:0] crc
);
    always_comb
    begin
        crc = 8'h00;
        for (int i = 63; i >= 0; i--)
            crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ cfg[i]) ? 8'h07 : 8'h00);
    end
endmodule // icc_host

// ===== tb/icc_checker_bench.sv
// Self-checking bench for the checksum checker
`timescale 1ns/1ps
module icc_checker_bench;
    logic REF_CLK = 0, RST_N = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
    logic NORMAL_MODE = 0, WB_ACK_O, IRQ, LIMP_HOME;
    logic [3:0] WB_SEL_I = 4'hF;
    logic [7:0] WB_ADR_I = 8'h00, c;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q;
    logic [63:0] CFG_DATA = 64'h0123_4567_89AB_CDEF;
    logic [31:0] rows [3][2] = '{'{32'h23A5, 32'h22A5},
        '{32'hFFFF_FFFF, 32'h22FF}, '{32'h1000, 32'h0}};
    int n_errors = 0, checks = 0, t;
    // Short check period keeps the run brief
    icc_checker #(.CHECK_CYCLES(20'd16)) icc_checker_i (
        .REF_CLK(REF_CLK),
        .RST_N(RST_N),
        .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I),
        .WB_ADR_I(WB_ADR_I),
        .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O),
        .WB_ACK_O(WB_ACK_O),
        .NORMAL_MODE(NORMAL_MODE),
        .CFG_DATA(CFG_DATA),
        .IRQ(IRQ),
        .LIMP_HOME(LIMP_HOME)
    );
    icc_host icc_host_i (.cfg(CFG_DATA), .crc(c));
    always #2.5 REF_CLK = ~REF_CLK;
    task chk(input logic [31:0] g, e);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        WB_CYC_I <= 1;
        WB_STB_I <= 1;
        WB_WE_I <= w;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        do @(posedge REF_CLK); while (WB_ACK_O !== 1 && ++n < 50);
        // A missing answer counts as a mismatch
        chk(WB_ACK_O, 1);
        r = WB_DAT_O;
        WB_CYC_I <= 0;
        WB_STB_I <= 0;
        @(posedge REF_CLK);
    endtask
    task wt(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask
    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ====
    initial
    begin
        wt(4);
        RST_N <= 1;
        wt(3);
        wb(0, 8'h00, 0, q);
        chk(q, 0);
        chk({IRQ, LIMP_HOME}, 0);
        foreach (rows[i])
        begin
            wb(1, 8'h00, rows[i][0], q);
            wb(0, 8'h00, 0, q);
            chk(q, rows[i][1]);
        end
        wb(0, 8'h40, 0, q);
        chk(q, 0);
        wb(1, 8'h00, {24'h02, ~c}, q);
        NORMAL_MODE <= 1;
        t = 0;
        while (IRQ !== 1 && t < 40)
        begin
            wt(1);
            t++;
        end
        chk(t > 15 && t < 21, 1);
        chk({IRQ, LIMP_HOME}, 3);
        wb(0, 8'h00, 0, q);
        chk(q[12], 1);
        wb(1, 8'h00, {24'h22, ~c}, q);
        wt(2);
        chk({IRQ, LIMP_HOME}, 1);
        NORMAL_MODE <= 0;
        wt(2);
        wb(1, 8'h00, {24'h10, ~c}, q);
        wb(0, 8'h00, 0, q);
        chk({q[12], IRQ, LIMP_HOME}, 0);
        wt(40);
        chk({IRQ, LIMP_HOME}, 0);
        NORMAL_MODE <= 1;
        wt(40);
        chk({IRQ, LIMP_HOME}, 2);
        NORMAL_MODE <= 0;
        wt(2);
        wb(1, 8'h00, {24'h12, c}, q);
        NORMAL_MODE <= 1;
        wt(40);
        chk({IRQ, LIMP_HOME}, 0);
        // Mid-run reset with the reference, the action bit and the flag set
        wb(1, 8'h00, {24'h02, ~c}, q);
        wt(20);
        chk({IRQ, LIMP_HOME}, 3);
        wb(0, 8'h04, 0, q);
        chk(q & 32'h0000_03FF, {22'h0, 2'b11, c});
        RST_N <= 0;
        NORMAL_MODE <= 0;
        wt(2);
        chk({IRQ, LIMP_HOME}, 0);
        RST_N <= 1;
        wt(3);
        wb(0, 8'h00, 0, q);
        chk(q, 0);
        wb(0, 8'h04, 0, q);
        chk(q, 0);
        // Exactly one check fits in 20 cycles of Normal mode
        wb(1, 8'h00, {24'h00, c}, q);
        NORMAL_MODE <= 1;
        wt(20);
        NORMAL_MODE <= 0;
        wb(0, 8'h04, 0, q);
        chk(q, {16'h0001, 8'h00, c});
        end_sim;
    end
    initial
    begin
        #20000;
        n_errors++;
        end_sim;
    end
endmodule // icc_checker_bench
